// ### design/port_sound_pkg.sv
package port_sound_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_PORT_CTRL = 8'h05;
  localparam logic [7:0] ADDR_KEY_SOUND = 8'h06;
  localparam logic [7:0] ADDR_ALERT_SOUND = 8'h07;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PORT_HI_BIT = 7;
  localparam int PORT_LO_BIT = 2;
  localparam int INT_PORT_BIT = 1;
  localparam int ALERT_LEVEL_BIT = 0;
  localparam int DUR_HI_BIT = 7;
  localparam int DUR_LO_BIT = 5;
  localparam int NUM_PORTS = PORT_HI_BIT - PORT_LO_BIT + 1;

  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [5:0] PORT_RESET = 6'h3F;
  localparam logic INT_PORT_RESET = 1'b1;
  localparam logic [7:0] KEY_SOUND_RESET = 8'h51;
  localparam logic [7:0] ALERT_SOUND_RESET = 8'hBB;
  localparam logic [2:0] DUR_CONTINUOUS = 3'h0;
  localparam logic [2:0] DUR_1000MS = 3'h7;
  localparam logic BUFFER_QUEUE = 1'b1;
  localparam logic [4:0] KEYSCAN_INT_OFF = 5'h00;
endpackage

// ### design/port_sound_regs.sv
`timescale 1ns/1ps
`default_nettype none
module port_sound_regs
  import port_sound_pkg::*;
(
  input wire logic CLK, // system clock, 40 MHz
  input wire logic RST_N, // async reset, active low
  input wire logic [7:0] REG_ADDR, // register address
  input wire logic REG_WR, // write strobe, one cycle
  input wire logic [7:0] REG_WDATA, // write data
  input wire logic REG_RD, // read strobe, one cycle
  output logic [7:0] REG_RDATA, // read data, valid cycle after REG_RD
  input wire logic [4:0] KEYSCAN_INT_CFG, // interrupt register bits 4..0
  input wire logic KEY_SOUND_EN, // configuration key-sound enable
  input wire logic ALERT_SOUND_EN, // configuration alert-sound enable
  input wire logic KEY_DEBOUNCED, // pulse: key(s) debounced
  input wire logic ALERT_IN, // alert input pin level
  output logic [5:0] PORT_O, // open-drain port 7..2 output level
  output logic [5:0] PORT_OE, // port 7..2 drive enable, high pulls low
  output logic INT_O, // interrupt pin output level
  output logic INT_OE, // interrupt pin drive enable
  output logic [7:0] SND_CMD, // command waiting for the sounder
  output logic SND_VALID, // a command is waiting
  input wire logic SND_TAKE // sounder controller takes the command
);
  logic [5:0] port_q;
  logic int_port_q;
  logic [7:1] key_sound_q;
  logic [7:1] alert_sound_q;
  logic alert_q;
  logic [7:0] rdata_q;
  logic [5:0] port_oe_q;
  logic int_oe_q;
  logic [5:0] port_o_q;
  logic int_o_q;
  logic wr_port;
  logic wr_key;
  logic wr_alert;
  logic alert_fall;
  logic key_fire;
  logic alert_fire;
  logic push;
  logic [7:0] push_cmd;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:1] fix_preset(input logic [7:0] wd);
    logic [7:1] v;
    v = wd[7:1];
    if (wd[DUR_HI_BIT:DUR_LO_BIT] == DUR_CONTINUOUS) begin
      v[DUR_HI_BIT:DUR_LO_BIT] = DUR_1000MS;
    end
    return v;
  endfunction

  function automatic logic [7:0] preset_cmd(input logic [7:1] p);
    return {p, BUFFER_QUEUE};
  endfunction

  assign wr_port = REG_WR && (REG_ADDR == ADDR_PORT_CTRL);
  assign wr_key = REG_WR && (REG_ADDR == ADDR_KEY_SOUND);
  assign wr_alert = REG_WR && (REG_ADDR == ADDR_ALERT_SOUND);

  // ****************************************************************
  // port control register
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      port_q <= PORT_RESET;
    end else if (wr_port) begin
      port_q <= REG_WDATA[PORT_HI_BIT:PORT_LO_BIT];
    end
  end

  // while key-scan interrupts are live that logic owns the pin
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_port_q <= INT_PORT_RESET;
    end else if (wr_port && KEYSCAN_INT_CFG == KEYSCAN_INT_OFF) begin
      int_port_q <= REG_WDATA[INT_PORT_BIT];
    end
  end

  // pins follow the register one cycle later, from flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      port_oe_q <= 6'h00;
      int_oe_q <= 1'b0;
      port_o_q <= 6'h00;
      int_o_q <= 1'b0;
    end else begin
      port_oe_q <= ~port_q;
      int_oe_q <= ~int_port_q;
      port_o_q <= 6'h00;
      int_o_q <= 1'b0;
    end
  end

  // ****************************************************************
  // sound presets
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      key_sound_q <= KEY_SOUND_RESET[7:1];
    end else if (wr_key) begin
      key_sound_q <= fix_preset(REG_WDATA);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      alert_sound_q <= ALERT_SOUND_RESET[7:1];
    end else if (wr_alert) begin
      alert_sound_q <= fix_preset(REG_WDATA);
    end
  end

  // ****************************************************************
  // sound triggers
  // ****************************************************************
  // reset to high so a low alert level at release counts as a falling edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      alert_q <= 1'b1;
    end else begin
      alert_q <= ALERT_IN;
    end
  end

  assign alert_fall = alert_q && !ALERT_IN;
  assign key_fire = KEY_DEBOUNCED && KEY_SOUND_EN;
  assign alert_fire = alert_fall && ALERT_SOUND_EN;
  assign push = key_fire || alert_fire;
  // both at once: the alert is the later command and keeps the slot
  assign push_cmd = alert_fire ? preset_cmd(alert_sound_q)
                               : preset_cmd(key_sound_q);

  sound_cmd_queue #(
    .WIDTH(8)
  ) u_queue (
    .clk(CLK),
    .rst_n(RST_N),
    .push(push),
    .push_cmd(push_cmd),
    .pop(SND_TAKE),
    .full(SND_VALID),
    .cmd(SND_CMD)
  );

  // ****************************************************************
  // read back
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_PORT_CTRL: rdata_q <= {port_q, int_port_q, ALERT_IN};
        ADDR_KEY_SOUND: rdata_q <= preset_cmd(key_sound_q);
        ADDR_ALERT_SOUND: rdata_q <= preset_cmd(alert_sound_q);
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign REG_RDATA = rdata_q;
  assign PORT_OE = port_oe_q;
  assign INT_OE = int_oe_q;
  assign PORT_O = port_o_q;
  assign INT_O = int_o_q;
endmodule
`default_nettype wire

// ### design/sound_cmd_queue.sv
`timescale 1ns/1ps
`default_nettype none
module sound_cmd_queue
  import port_sound_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic push, // append a command
  input wire logic [WIDTH-1:0] push_cmd, // command to append
  input wire logic pop, // consumer takes the queued command
  output logic full, // one command is waiting
  output logic [WIDTH-1:0] cmd // waiting command
);
  generate
    if (WIDTH < 2) begin : g_bad_width
      $error("sound_cmd_queue needs at least two bits");
    end
  endgenerate

  logic full_q;
  logic [WIDTH-1:0] cmd_q;

  // ****************************************************************
  // single slot: a push on a full slot overwrites the older command
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= '0;
    end else if (push) begin
      cmd_q <= push_cmd;
    end
  end

  // push wins over a pop in the same cycle so no command is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_q <= 1'b0;
    end else if (push) begin
      full_q <= 1'b1;
    end else if (pop) begin
      full_q <= 1'b0;
    end
  end

  assign full = full_q;
  assign cmd = cmd_q;
endmodule
`default_nettype wire

// ### testbench/port_sound_props.sv
`timescale 1ns/1ps
`default_nettype none
module port_sound_props
  import port_sound_pkg::*;
(
  input wire logic CLK, // system clock
  input wire logic RST_N, // async reset, active low
  input wire logic REG_WR, // write strobe
  input wire logic REG_RD, // read strobe
  input wire logic KEY_DEBOUNCED, // key event pulse
  input wire logic ALERT_IN, // alert pin level
  input wire logic KEY_SOUND_EN, // key-sound enable
  input wire logic ALERT_SOUND_EN, // alert-sound enable
  input wire logic INT_OE, // interrupt pin drive enable
  input wire logic SND_VALID, // command waiting
  input wire logic SND_TAKE, // sounder takes command
  input wire logic [7:0] REG_ADDR, // register address
  input wire logic [7:0] REG_WDATA, // write data
  input wire logic [7:0] REG_RDATA, // read data
  input wire logic [7:0] SND_CMD, // waiting command
  input wire logic [5:0] PORT_OE, // port drive enables
  input wire logic [4:0] KEYSCAN_INT_CFG // interrupt register bits
);
  logic hi_q;
  // starts high: a low level at release counts as an edge
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N) hi_q <= 1'b1;
    else hi_q <= ALERT_IN;
  wire logic al = ALERT_SOUND_EN && !ALERT_IN && hi_q;
  wire logic ky = KEY_DEBOUNCED && KEY_SOUND_EN;
  wire logic pw = REG_WR && REG_ADDR == ADDR_PORT_CTRL;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  port_drive_a: assert property (pw |-> ##2
    PORT_OE == ~$past(REG_WDATA[7:2], 2)) else $error("port drive");
  int_gate_a: assert property (pw && KEYSCAN_INT_CFG == 5'h00 |-> ##2
    INT_OE == !$past(REG_WDATA[1], 2)) else $error("int drive");
  alert_read_a: assert property (REG_RD && REG_ADDR == ADDR_PORT_CTRL
    |=> REG_RDATA[0] == $past(ALERT_IN)) else $error("alert level");
  key_send_a: assert property (ky |=> SND_VALID && SND_CMD[0])
    else $error("key command");
  alert_send_a: assert property (al |=> SND_VALID && SND_CMD[0])
    else $error("alert command");
  preset_low_a: assert property (REG_RD && REG_ADDR[7:1] == 7'h03
    |=> REG_RDATA[0]) else $error("preset bit");
  take_clear_a: assert property (SND_TAKE && !ky && !al |=> !SND_VALID)
    else $error("take clear");
  reset_idle_a: assert property (disable iff (1'b0) !RST_N |->
    PORT_OE == 6'h00 && !INT_OE && !SND_VALID) else $error("reset idle");
  cover property (ky);
  cover property (al);
  cover property (pw && KEYSCAN_INT_CFG == 5'h00);
  cover property (SND_TAKE && ky);
endmodule
`default_nettype wire

// ### testbench/port_sound_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module port_sound_regs_test;
  import port_sound_pkg::*;
  logic CLK = 0, RST_N = 1, REG_WR = 0, REG_RD = 0, KEY_DEBOUNCED = 0;
  logic ALERT_IN = 1, KEY_SOUND_EN = 0, ALERT_SOUND_EN = 0;
  logic INT_O, INT_OE, SND_VALID, SND_TAKE;
  logic [7:0] REG_ADDR = 0, REG_WDATA = 0, REG_RDATA, SND_CMD;
  logic [7:0] km = 8'h51, am = 8'hBB;
  logic [7:1] pm = 7'h7F;
  logic [5:0] PORT_O, PORT_OE;
  logic [4:0] KEYSCAN_INT_CFG = 0;
  logic [3:0] dly = 0;
  logic [31:0] r = 32'hae1a_3b65;
  int fail_count = 0, compares = 0, n;
  port_sound_regs port_sound_regs_inst (
    .CLK(CLK),
    .RST_N(RST_N),
    .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .KEYSCAN_INT_CFG(KEYSCAN_INT_CFG),
    .KEY_SOUND_EN(KEY_SOUND_EN),
    .ALERT_SOUND_EN(ALERT_SOUND_EN),
    .KEY_DEBOUNCED(KEY_DEBOUNCED),
    .ALERT_IN(ALERT_IN),
    .PORT_O(PORT_O),
    .PORT_OE(PORT_OE),
    .INT_O(INT_O),
    .INT_OE(INT_OE),
    .SND_CMD(SND_CMD),
    .SND_VALID(SND_VALID),
    .SND_TAKE(SND_TAKE)
  );
  sound_taker sound_taker_inst (.clk(CLK), .rst_n(RST_N), .valid(SND_VALID),
    .dly(dly), .take(SND_TAKE));
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] st(logic [7:0] d);
    return {d[7:5] == 3'h0 ? 3'h7 : d[7:5], d[4:1], 1'b1};
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    {REG_ADDR, REG_WDATA, REG_WR} <= {a, d, 1'b1};
    if (a == 8'h05) pm = {d[7:2], KEYSCAN_INT_CFG == 5'h00 ? d[1] : pm[1]};
    if (a == 8'h06) km = st(d);
    if (a == 8'h07) am = st(d);
    @(posedge CLK);
    REG_WR <= 0;
  endtask
  task automatic rd(logic [7:0] a);
    {REG_ADDR, REG_RD} <= {a, 1'b1};
    @(posedge CLK);
    REG_RD <= 0;
    @(negedge CLK);
    chk(REG_RDATA, a == 8'h05 ? {pm, ALERT_IN} : a == 8'h06 ? km :
      a == 8'h07 ? am : 8'h00);
    @(posedge CLK);
  endtask
  task automatic wv(logic v);
    for (n = 0; n < 30 && SND_VALID !== v; n++) @(negedge CLK);
    chk({7'h0, SND_VALID}, {7'h0, v});
    if (n == 30) wrap_up();
  endtask
  task automatic go(logic k);
    if (k) KEY_DEBOUNCED <= 1;
    else ALERT_IN <= 0;
    @(posedge CLK);
    {KEY_DEBOUNCED, ALERT_IN} <= 2'b01;
  endtask
  initial forever #12.5 CLK = ~CLK;
  initial begin
    // reset by an edge at time zero so every flop starts known
    RST_N <= 0;
    repeat (5) @(posedge CLK);
    RST_N <= 1;
    @(posedge CLK);
    for (int a = 4; a < 9; a++) rd(8'(a));
    for (int i = 0; i < 60; i++) begin
      r = nx(r);
      KEYSCAN_INT_CFG <= r[9] ? 5'h00 : r[14:10];
      @(posedge CLK);
      wr({6'h01, r[1:0]}, r[31:24]);
      ALERT_IN <= r[8];
      rd({6'h01, r[1:0]});
      @(negedge CLK);
      chk({~PORT_OE, 2'h0}, {pm[7:2], 2'h0});
      chk({7'h0, !INT_OE}, {7'h0, pm[1]});
      chk({2'h0, PORT_O}, 8'h00);
      chk({7'h0, INT_O}, 8'h00);
      @(posedge CLK);
    end
    ALERT_IN <= 1;
    for (int i = 0; i < 20; i++) begin
      r = nx(r);
      {KEY_SOUND_EN, ALERT_SOUND_EN, dly} <= {r[0], r[1], 1'b0, r[5:3]};
      @(posedge CLK);
      go(r[2]);
      if (r[2] ? r[0] : r[1]) begin
        wv(1);
        chk(SND_CMD, r[2] ? km : am);
      end else begin
        repeat (3) @(negedge CLK);
        chk({7'h0, SND_VALID}, 8'h00);
      end
      wv(0);
      @(posedge CLK);
    end
    // a push in the cycle the taker consumes must survive
    {KEY_SOUND_EN, dly} <= 5'h10;
    @(posedge CLK);
    go(1);
    @(posedge CLK);
    go(1);
    @(negedge CLK);
    chk({7'h0, SND_VALID}, 8'h01);
    wv(0);
    @(posedge CLK);
    // distinct presets so a replaced command is told apart
    wr(8'h06, 8'h02);
    rd(8'h06);
    wr(8'h07, 8'h44);
    rd(8'h07);
    // slow taker so the alert command lands on a full slot
    {KEY_SOUND_EN, ALERT_SOUND_EN, dly} <= 6'h3F;
    @(posedge CLK);
    go(1);
    @(posedge CLK);
    go(0);
    repeat (2) @(negedge CLK);
    chk(SND_CMD, am);
    wv(0);
    // key and alert in one cycle: the alert command keeps the slot
    @(posedge CLK);
    {KEY_DEBOUNCED, ALERT_IN} <= 2'b10;
    @(posedge CLK);
    {KEY_DEBOUNCED, ALERT_IN} <= 2'b01;
    wv(1);
    chk(SND_CMD, am);
    wv(0);
    wrap_up();
  end
endmodule
bind port_sound_regs port_sound_props port_sound_props_inst (
  .CLK(CLK),
  .RST_N(RST_N),
  .REG_WR(REG_WR),
  .REG_RD(REG_RD),
  .KEY_DEBOUNCED(KEY_DEBOUNCED),
  .ALERT_IN(ALERT_IN),
  .KEY_SOUND_EN(KEY_SOUND_EN),
  .ALERT_SOUND_EN(ALERT_SOUND_EN),
  .INT_OE(INT_OE),
  .SND_VALID(SND_VALID),
  .SND_TAKE(SND_TAKE),
  .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA),
  .SND_CMD(SND_CMD),
  .PORT_OE(PORT_OE),
  .KEYSCAN_INT_CFG(KEYSCAN_INT_CFG)
);
`default_nettype wire

// ### testbench/sound_taker.sv
`timescale 1ns/1ps
`default_nettype none
module sound_taker (
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic valid, // command waiting
  input wire logic [3:0] dly, // stall cycles before taking
  output logic take // consume pulse
);
  logic [3:0] w_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) {w_q, take} <= 5'h00;
    else {w_q, take} <= valid && !take ? {w_q + 4'h1, w_q >= dly} : 5'h00;
endmodule
`default_nettype wire
